// file: dv/gdcl_ctrl_model.sv
// far-side controller model: register bus master
`timescale 1ns/1ns
`default_nettype none
module gdcl_ctrl_model (
    input  wire logic        MCLK,
    input  wire logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY,
    input  wire logic        S_AXI_RVALID,
    input  wire logic [1:0]  S_AXI_BRESP, S_AXI_RRESP,
    input  wire logic [31:0] S_AXI_RDATA,
    output logic             S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY,
    output logic             S_AXI_ARVALID, S_AXI_RREADY,
    output logic [7:0]       S_AXI_AWADDR, S_AXI_ARADDR,
    output logic [31:0]      S_AXI_WDATA,
    output logic [3:0]       S_AXI_WSTRB
);
    initial begin
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = 52'h0;
    end
    // both lanes on: lock and codes go together
    task automatic wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
        @(posedge MCLK);
        S_AXI_AWADDR  <= a;
        S_AXI_WDATA   <= dt;
        S_AXI_WSTRB   <= 4'h3;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID  <= 1'b1;
        S_AXI_BREADY  <= 1'b1;
        do begin
            @(posedge MCLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (!S_AXI_BVALID);
        rs = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
        @(posedge MCLK);
        S_AXI_ARADDR  <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY  <= 1'b1;
        do begin
            @(posedge MCLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (!S_AXI_RVALID);
        dt = S_AXI_RDATA;
        rs = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
    endtask : rd
endmodule : gdcl_ctrl_model
`default_nettype wire

// file: dv/gdcl_top_bench.sv
// self-checking bench for the gate drive register bank
`timescale 1ns/1ns
`default_nettype none
`include "gdcl_cfg.svh"
module gdcl_top_bench;
    import gdcl_pkg::*;
    localparam int LIM = 100;
    localparam logic [1:0] OK = `GDCL_RESP_OKAY;
    localparam logic [1:0] SE = `GDCL_RESP_SLVERR;
    logic MCLK, RSTN, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
    logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, COAST;
    logic RETRY_TIME_SELECT, DRAIN_SOURCE_OVERCURRENT, SENSE_OVERCURRENT, PWM_NEW_INPUT;
    logic DRAIN_SOURCE_OVERCURRENT_FAULT, SENSE_OVERCURRENT_FAULT, CYCLE_BY_CYCLE_CLEAR;
    logic REGS_LOCKED, BRAKE, CLEAR_FAULT;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, PEAK_DRIVE_TIME, r;
    logic [3:0]  S_AXI_WSTRB, HIGH_SIDE_SOURCE_CURRENT, HIGH_SIDE_SINK_CURRENT;
    logic [3:0]  LOW_SIDE_SOURCE_CURRENT, LOW_SIDE_SINK_CURRENT;
    logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, PEAK_DRIVE_CYCLES;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
    gdcl_ocm_t   OVERCURRENT_MODE;
    int          miscompares = 0;
    int          check_count = 0;
    int          cyc = 0;
    // short retry count keeps the run small
    gdcl_top #(.RETRY_LONG_CYCLES(`GDCL_RETRY_CW'(LIM))) gdcl_top_inst (.*);
    gdcl_ctrl_model gdcl_ctrl_model_inst (.*);
    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic summarize;
        if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrc(input logic [7:0] a, input logic [10:0] v, input logic [1:0] er);
        gdcl_ctrl_model_inst.wr(a, {21'h0, v}, r);
        chk(r, er);
    endtask : wrc
    task automatic rdc(input logic [7:0] a, input logic [10:0] v, input logic [1:0] er);
        gdcl_ctrl_model_inst.rd(a, d, r);
        chk(d, {21'h0, v});
        chk(r, er);
    endtask : rdc
    task automatic pulse(input logic e, input logic p);
        @(posedge MCLK);
        {DRAIN_SOURCE_OVERCURRENT, SENSE_OVERCURRENT, PWM_NEW_INPUT} <= {e, e, p};
        @(posedge MCLK);
        {DRAIN_SOURCE_OVERCURRENT, SENSE_OVERCURRENT, PWM_NEW_INPUT} <= 3'h0;
    endtask : pulse
    task automatic fchk(input int n, input logic f);
        repeat (n) @(posedge MCLK);
        #1 chk({DRAIN_SOURCE_OVERCURRENT_FAULT, SENSE_OVERCURRENT_FAULT}, {f, f});
    endtask : fchk
    function automatic logic [27:0] outs();
        return {REGS_LOCKED, CYCLE_BY_CYCLE_CLEAR, PEAK_DRIVE_TIME, PEAK_DRIVE_CYCLES,
            HIGH_SIDE_SOURCE_CURRENT, HIGH_SIDE_SINK_CURRENT, LOW_SIDE_SOURCE_CURRENT,
            LOW_SIDE_SINK_CURRENT};
    endfunction : outs
    function automatic logic [27:0] exo(input logic lk, cb, input logic [1:0] td,
                                        input logic [7:0] hs, ls);
        return {lk, cb, td, 8'h19 << td, hs, ls};
    endfunction : exo
    initial begin
        RSTN = 1'b0;
        OVERCURRENT_MODE = OCM_RETRY;
        {RETRY_TIME_SELECT, DRAIN_SOURCE_OVERCURRENT, SENSE_OVERCURRENT, PWM_NEW_INPUT} = 4'h0;
        repeat (4) @(posedge MCLK);
        RSTN <= 1'b1;
        #1 chk(outs(), exo(1'b0, 1'b1, 2'h3, 8'hFF, 8'hFF));
        rdc(8'h0C, 11'h3FF, OK);
        rdc(8'h10, 11'h7FF, OK);
        for (int k = 0; k < 8; k++) begin
            if (k == 6) continue;
            wrc(8'h0C, {k[2:0], 8'hA5}, OK);
            chk(REGS_LOCKED, 1'b0);
        end
        rdc(8'h0C, 11'h3A5, OK);
        for (int t = 0; t < 4; t++) begin
            wrc(8'h10, {t[0], t[1:0], 8'h5A}, OK);
            chk(outs(), exo(1'b0, t[0], t[1:0], 8'hA5, 8'h5A));
        end
        wrc(8'h0C, 11'h6C3, OK);
        chk(outs(), exo(1'b1, 1'b1, 2'h3, 8'hC3, 8'h5A));
        wrc(8'h10, 11'h000, OK);
        wrc(8'h0C, 11'h7F0, OK);
        chk(outs(), exo(1'b1, 1'b1, 2'h3, 8'hC3, 8'h5A));
        wrc(8'h08, 11'h006, OK);
        chk({COAST, BRAKE}, 2'h3);
        rdc(8'h08, 11'h006, OK);
        wrc(8'h0C, 11'h300, OK);
        chk(outs(), exo(1'b0, 1'b1, 2'h3, 8'hC3, 8'h5A));
        wrc(8'h14, 11'h000, SE);
        rdc(8'h20, 11'h000, SE);
        pulse(1'b1, 1'b0);
        fchk(LIM - 10, 1'b1);
        fchk(20, 1'b0);
        pulse(1'b1, 1'b0);
        fchk(5, 1'b1);
        pulse(1'b0, 1'b1);
        fchk(2, 1'b0);
        wrc(8'h10, 11'h35A, OK);
        chk(CYCLE_BY_CYCLE_CLEAR, 1'b0);
        pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b1);
        fchk(5, 1'b1);
        fchk(LIM, 1'b0);
        RETRY_TIME_SELECT <= 1'b1;
        pulse(1'b1, 1'b0);
        fchk(2400, 1'b1);
        fchk(110, 1'b0);
        wrc(8'h10, 11'h75A, OK);
        for (int m = 0; m < 3; m += 2) begin
            OVERCURRENT_MODE <= gdcl_ocm_t'(m[1:0]);
            pulse(1'b1, 1'b0);
            pulse(1'b0, 1'b1);
            fchk(LIM + 20, 1'b1);
            wrc(8'h08, 11'h001, OK);
            fchk(2, 1'b0);
        end
        OVERCURRENT_MODE <= OCM_OFF;
        pulse(1'b1, 1'b0);
        fchk(2, 1'b0);
        summarize();
    end
endmodule : gdcl_top_bench
`default_nettype wire

// file: dv/gdcl_top_checker.sv
// port checks of the gate drive register bank
`timescale 1ns/1ns
`default_nettype none
`include "gdcl_cfg.svh"
module gdcl_top_checker (
    input wire logic        MCLK, RSTN, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, REGS_LOCKED,
    input wire logic        DRAIN_SOURCE_OVERCURRENT, CLEAR_FAULT,
    input wire logic        DRAIN_SOURCE_OVERCURRENT_FAULT,
    input wire logic [1:0]  S_AXI_BRESP, PEAK_DRIVE_TIME, OVERCURRENT_MODE,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [3:0]  HIGH_SIDE_SOURCE_CURRENT, LOW_SIDE_SINK_CURRENT,
    input wire logic [7:0]  PEAK_DRIVE_CYCLES
);
    import gdcl_pkg::*;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID
        && $stable(S_AXI_BRESP)) else $error("b dropped");
    a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
        && $stable(S_AXI_RDATA)) else $error("r dropped");
    a_ar_ready: assert property (S_AXI_ARREADY == !S_AXI_RVALID) else $error("ar ready");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("r late");
    a_lock_moves: assert property ($changed(REGS_LOCKED) |-> $rose(S_AXI_BVALID))
        else $error("lock moved");
    a_locked_frozen: assert property ($past(REGS_LOCKED) |-> $stable(PEAK_DRIVE_TIME)
        && $stable(HIGH_SIDE_SOURCE_CURRENT) && $stable(LOW_SIDE_SINK_CURRENT))
        else $error("codes moved");
    a_cycles_map: assert property (PEAK_DRIVE_CYCLES == (8'h19 << PEAK_DRIVE_TIME))
        else $error("drive cycles wrong");
    a_fault_cause: assert property ($rose(DRAIN_SOURCE_OVERCURRENT_FAULT) |->
        $past(DRAIN_SOURCE_OVERCURRENT) && $past(OVERCURRENT_MODE) != OCM_OFF)
        else $error("no cause");
    a_clear_pulse: assert property (CLEAR_FAULT |=> !CLEAR_FAULT) else $error("clear too long");
    c_lock: cover property ($rose(REGS_LOCKED));
    c_retry: cover property ($fell(DRAIN_SOURCE_OVERCURRENT_FAULT));
    c_slverr: cover property (S_AXI_BVALID && S_AXI_BRESP == `GDCL_RESP_SLVERR);
endmodule : gdcl_top_checker
bind gdcl_top gdcl_top_checker chk_inst (.*);
`default_nettype wire

// file: rtl/gdcl_axil.sv
// axi4-lite slave front end of the gate drive register bank
`timescale 1ns/1ns
`default_nettype none
`include "gdcl_cfg.svh"
module gdcl_axil (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic [7:0]             awaddr,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    input  wire logic [7:0]             araddr,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    output logic                        wr_en,
    output logic [`GDCL_IDX_W-1:0]      wr_idx,
    output logic [31:0]                 wr_data,
    output logic [3:0]                  wr_strb,
    input  wire logic                   wr_hit,
    output logic [`GDCL_IDX_W-1:0]      rd_idx,
    input  wire logic [31:0]            rd_data,
    input  wire logic                   rd_hit
);
    import gdcl_pkg::*;

    gdcl_axil_t s;
    gdcl_axil_t next_s;

    assign awready = !s.aw_full;
    assign wready  = !s.w_full;
    assign arready = !s.rvalid;
    // commit waits for a pending response so only one write is in flight
    assign wr_en   = s.aw_full && s.w_full && !s.bvalid;
    assign wr_idx  = s.aw_idx;
    assign wr_data = s.wdata;
    assign wr_strb = s.wstrb;
    assign rd_idx  = araddr[7:2];
    assign bvalid  = s.bvalid;
    assign bresp   = s.bresp;
    assign rvalid  = s.rvalid;
    assign rdata   = s.rdata;
    assign rresp   = s.rresp;

    always_comb begin
        next_s = s;
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (wr_en) begin
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = wr_hit ? `GDCL_RESP_OKAY : `GDCL_RESP_SLVERR;
        end
        if (awvalid && !s.aw_full) begin
            next_s.aw_full = 1'b1;
            next_s.aw_idx  = awaddr[7:2];
        end
        if (wvalid && !s.w_full) begin
            next_s.w_full = 1'b1;
            next_s.wdata  = wdata;
            next_s.wstrb  = wstrb;
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd_hit ? rd_data : 32'h0;
            next_s.rresp  = rd_hit ? `GDCL_RESP_OKAY : `GDCL_RESP_SLVERR;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule : gdcl_axil
`default_nettype wire

// file: rtl/gdcl_cfg.svh
// constants of the gate drive configuration and lock register bank
`ifndef GDCL_CFG_SVH
`define GDCL_CFG_SVH

// clock period
`define GDCL_CLK_NS        20

// register indices (byte address is four times the index)
`define GDCL_IDX_W         6
`define GDCL_IDX_DRV_CTRL  6'h02
`define GDCL_IDX_GATE_HS   6'h03
`define GDCL_IDX_GATE_LS   6'h04

// field positions
`define GDCL_LOCK_HI       10
`define GDCL_LOCK_LO       8
`define GDCL_SRC_HI        7
`define GDCL_SRC_LO        4
`define GDCL_SNK_HI        3
`define GDCL_SNK_LO        0
`define GDCL_CBC_BIT       10
`define GDCL_PEAK_DRIVE_TIME_HI     9
`define GDCL_PEAK_DRIVE_TIME_LO     8
`define GDCL_COAST_BIT     2
`define GDCL_BRAKE_BIT     1
`define GDCL_CLRFLT_BIT    0
`define GDCL_STRB_LOW      0
`define GDCL_STRB_HIGH     1

// lock codes and reset values
`define GDCL_LOCK_ON       3'h6
`define GDCL_LOCK_OFF      3'h3
`define GDCL_CURRENT_RST   4'hF
`define GDCL_PEAK_DRIVE_TIME_RST    2'h3
`define GDCL_CBC_RST       1'h1

// peak drive times
`define GDCL_TDRIVE0_NS    500
`define GDCL_TDRIVE1_NS    1000
`define GDCL_TDRIVE2_NS    2000
`define GDCL_TDRIVE3_NS    4000

// overcurrent retry times
`define GDCL_RETRY_LONG_NS  8000000
`define GDCL_RETRY_SHORT_NS 50000
`define GDCL_RETRY_CW       19

// bus responses
`define GDCL_RESP_OKAY     2'h0
`define GDCL_RESP_SLVERR   2'h2

`endif

// file: rtl/gdcl_pkg.sv
// types shared by the gate drive configuration and lock register bank
`include "gdcl_cfg.svh"
package gdcl_pkg;

    typedef enum logic [1:0] {
        OCM_LATCH  = 2'h0,
        OCM_RETRY  = 2'h1,
        OCM_REPORT = 2'h2,
        OCM_OFF    = 2'h3
    } gdcl_ocm_t;

    typedef enum logic [1:0] {
        RS_IDLE  = 2'h0,
        RS_RETRY = 2'h1,
        RS_LATCH = 2'h3
    } gdcl_rstate_t;

    typedef struct packed {
        gdcl_rstate_t                st;
        logic [`GDCL_RETRY_CW-1:0]   cnt;
        logic                        fault;
    } gdcl_retry_t;

    typedef struct packed {
        logic                        aw_full;
        logic [`GDCL_IDX_W-1:0]      aw_idx;
        logic                        w_full;
        logic [31:0]                 wdata;
        logic [3:0]                  wstrb;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        rvalid;
        logic [31:0]                 rdata;
        logic [1:0]                  rresp;
    } gdcl_axil_t;

    typedef struct packed {
        logic [2:0]                  lock;
        logic [3:0]                  hs_src;
        logic [3:0]                  hs_snk;
        logic [3:0]                  ls_src;
        logic [3:0]                  ls_snk;
        logic [1:0]                  peak_drive_time;
        logic [7:0]                  drive_cycles;
        logic                        cbc;
        logic                        coast;
        logic                        brake;
        logic                        clr_pulse;
    } gdcl_regs_t;

endpackage : gdcl_pkg

// file: rtl/gdcl_retry.sv
// overcurrent fault hold and automatic retry for one fault source
`timescale 1ns/1ns
`default_nettype none
`include "gdcl_cfg.svh"
module gdcl_retry #(
    parameter logic [`GDCL_RETRY_CW-1:0] LONG_CYCLES = `GDCL_RETRY_CW'(400000)
) (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire gdcl_pkg::gdcl_ocm_t    mode,
    input  wire logic                   cbc,
    input  wire logic                   retry_sel,
    input  wire logic                   clr_flt,
    input  wire logic                   detect,
    input  wire logic                   pwm_new,
    output logic                        fault
);
    import gdcl_pkg::*;

    localparam logic [`GDCL_RETRY_CW-1:0] SHORT_CYCLES =
        `GDCL_RETRY_CW'(`GDCL_RETRY_SHORT_NS / `GDCL_CLK_NS);

    gdcl_retry_t s;
    gdcl_retry_t next_s;
    logic [`GDCL_RETRY_CW-1:0] limit;
    logic                      expire;

    assign limit  = retry_sel ? SHORT_CYCLES : LONG_CYCLES;
    // the early clear on a new pwm edge only counts in retry mode
    assign expire = (s.cnt >= limit - `GDCL_RETRY_CW'(1))
                    || (cbc && pwm_new && mode == OCM_RETRY);
    assign fault  = s.fault;

    always_comb begin
        next_s = s;
        unique case (s.st)
            RS_IDLE: begin
                if (detect && mode == OCM_RETRY) begin
                    next_s.st  = RS_RETRY;
                    next_s.cnt = '0;
                end else if (detect && (mode == OCM_LATCH || mode == OCM_REPORT)) begin
                    next_s.st = RS_LATCH;
                end
            end
            RS_RETRY: begin
                next_s.cnt = s.cnt + `GDCL_RETRY_CW'(1);
                if (expire) begin
                    // a new event in the clearing cycle restarts the wait
                    next_s.st  = detect ? RS_RETRY : RS_IDLE;
                    next_s.cnt = '0;
                end
            end
            RS_LATCH: begin
                if (clr_flt && !detect) begin
                    next_s.st = RS_IDLE;
                end
            end
            default: begin
                next_s.st = RS_IDLE;
            end
        endcase
        next_s.fault = (next_s.st != RS_IDLE);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule : gdcl_retry
`default_nettype wire

// file: rtl/gdcl_top.sv
// gate drive current, drive time and write lock register bank with axi4-lite access
`timescale 1ns/1ns
`default_nettype none
`include "gdcl_cfg.svh"
module gdcl_top #(
    parameter logic [`GDCL_RETRY_CW-1:0] RETRY_LONG_CYCLES =
        `GDCL_RETRY_CW'(`GDCL_RETRY_LONG_NS / `GDCL_CLK_NS)
) (
    input  wire logic                   MCLK,
    input  wire logic                   RSTN,
    input  wire logic [7:0]             S_AXI_AWADDR,
    input  wire logic                   S_AXI_AWVALID,
    output logic                        S_AXI_AWREADY,
    input  wire logic [31:0]            S_AXI_WDATA,
    input  wire logic [3:0]             S_AXI_WSTRB,
    input  wire logic                   S_AXI_WVALID,
    output logic                        S_AXI_WREADY,
    output logic [1:0]                  S_AXI_BRESP,
    output logic                        S_AXI_BVALID,
    input  wire logic                   S_AXI_BREADY,
    input  wire logic [7:0]             S_AXI_ARADDR,
    input  wire logic                   S_AXI_ARVALID,
    output logic                        S_AXI_ARREADY,
    output logic [31:0]                 S_AXI_RDATA,
    output logic [1:0]                  S_AXI_RRESP,
    output logic                        S_AXI_RVALID,
    input  wire logic                   S_AXI_RREADY,
    input  wire gdcl_pkg::gdcl_ocm_t    OVERCURRENT_MODE,
    input  wire logic                   RETRY_TIME_SELECT,
    input  wire logic                   DRAIN_SOURCE_OVERCURRENT,
    input  wire logic                   SENSE_OVERCURRENT,
    input  wire logic                   PWM_NEW_INPUT,
    output logic                        DRAIN_SOURCE_OVERCURRENT_FAULT,
    output logic                        SENSE_OVERCURRENT_FAULT,
    output logic [3:0]                  HIGH_SIDE_SOURCE_CURRENT,
    output logic [3:0]                  HIGH_SIDE_SINK_CURRENT,
    output logic [3:0]                  LOW_SIDE_SOURCE_CURRENT,
    output logic [3:0]                  LOW_SIDE_SINK_CURRENT,
    output logic [1:0]                  PEAK_DRIVE_TIME,
    output logic [7:0]                  PEAK_DRIVE_CYCLES,
    output logic                        CYCLE_BY_CYCLE_CLEAR,
    output logic                        REGS_LOCKED,
    output logic                        COAST,
    output logic                        BRAKE,
    output logic                        CLEAR_FAULT
);
    import gdcl_pkg::*;

    // ----------------------------------------------------------------
    // state and bus wiring
    // ----------------------------------------------------------------
    gdcl_regs_t                r;
    gdcl_regs_t                next_r;
    logic                      wr_en;
    logic [`GDCL_IDX_W-1:0]    wr_idx;
    logic [31:0]               wr_data;
    logic [3:0]                wr_strb;
    logic                      wr_hit;
    logic [`GDCL_IDX_W-1:0]    rd_idx;
    logic [31:0]               rd_data;
    logic                      rd_hit;
    logic                      locked;
    logic [1:0]                oc_detect;
    logic [1:0]                oc_fault;

    gdcl_axil u_axil (
        .clk     (MCLK),
        .rstn    (RSTN),
        .awaddr  (S_AXI_AWADDR),
        .awvalid (S_AXI_AWVALID),
        .awready (S_AXI_AWREADY),
        .wdata   (S_AXI_WDATA),
        .wstrb   (S_AXI_WSTRB),
        .wvalid  (S_AXI_WVALID),
        .wready  (S_AXI_WREADY),
        .bresp   (S_AXI_BRESP),
        .bvalid  (S_AXI_BVALID),
        .bready  (S_AXI_BREADY),
        .araddr  (S_AXI_ARADDR),
        .arvalid (S_AXI_ARVALID),
        .arready (S_AXI_ARREADY),
        .rdata   (S_AXI_RDATA),
        .rresp   (S_AXI_RRESP),
        .rvalid  (S_AXI_RVALID),
        .rready  (S_AXI_RREADY),
        .wr_en   (wr_en),
        .wr_idx  (wr_idx),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_hit  (wr_hit),
        .rd_idx  (rd_idx),
        .rd_data (rd_data),
        .rd_hit  (rd_hit)
    );

    // each step of the drive-time code doubles the time, from the shortest time at code 0
    function automatic logic [7:0] drive_cycles(input logic [1:0] code);
        return 8'(`GDCL_TDRIVE0_NS / `GDCL_CLK_NS) << code;
    endfunction : drive_cycles

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    assign locked = (r.lock == `GDCL_LOCK_ON);
    assign wr_hit = (wr_idx == `GDCL_IDX_DRV_CTRL) || (wr_idx == `GDCL_IDX_GATE_HS)
                    || (wr_idx == `GDCL_IDX_GATE_LS);

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h0;
        unique case (rd_idx)
            `GDCL_IDX_DRV_CTRL: begin
                // the fault clear bit always reads back as zero
                rd_data[`GDCL_COAST_BIT] = r.coast;
                rd_data[`GDCL_BRAKE_BIT] = r.brake;
            end
            `GDCL_IDX_GATE_HS: begin
                rd_data[`GDCL_LOCK_HI:`GDCL_LOCK_LO] = r.lock;
                rd_data[`GDCL_SRC_HI:`GDCL_SRC_LO]   = r.hs_src;
                rd_data[`GDCL_SNK_HI:`GDCL_SNK_LO]   = r.hs_snk;
            end
            `GDCL_IDX_GATE_LS: begin
                rd_data[`GDCL_CBC_BIT]                   = r.cbc;
                rd_data[`GDCL_PEAK_DRIVE_TIME_HI:`GDCL_PEAK_DRIVE_TIME_LO] = r.peak_drive_time;
                rd_data[`GDCL_SRC_HI:`GDCL_SRC_LO]       = r.ls_src;
                rd_data[`GDCL_SNK_HI:`GDCL_SNK_LO]       = r.ls_snk;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // register writes and lock
    // ----------------------------------------------------------------
    always_comb begin
        next_r           = r;
        next_r.clr_pulse = 1'b0;
        if (wr_en) begin
            unique case (wr_idx)
                `GDCL_IDX_DRV_CTRL: begin
                    // these three bits stay writable under the lock
                    if (wr_strb[`GDCL_STRB_LOW]) begin
                        next_r.coast     = wr_data[`GDCL_COAST_BIT];
                        next_r.brake     = wr_data[`GDCL_BRAKE_BIT];
                        next_r.clr_pulse = wr_data[`GDCL_CLRFLT_BIT];
                    end
                end
                `GDCL_IDX_GATE_HS: begin
                    if (wr_strb[`GDCL_STRB_HIGH]) begin
                        if (!locked && wr_data[`GDCL_LOCK_HI:`GDCL_LOCK_LO] == `GDCL_LOCK_ON) begin
                            next_r.lock = `GDCL_LOCK_ON;
                        end else if (locked
                                     && wr_data[`GDCL_LOCK_HI:`GDCL_LOCK_LO] == `GDCL_LOCK_OFF) begin
                            next_r.lock = `GDCL_LOCK_OFF;
                        end
                    end
                    if (!locked && wr_strb[`GDCL_STRB_LOW]) begin
                        next_r.hs_src = wr_data[`GDCL_SRC_HI:`GDCL_SRC_LO];
                        next_r.hs_snk = wr_data[`GDCL_SNK_HI:`GDCL_SNK_LO];
                    end
                end
                `GDCL_IDX_GATE_LS: begin
                    if (!locked && wr_strb[`GDCL_STRB_LOW]) begin
                        next_r.ls_src = wr_data[`GDCL_SRC_HI:`GDCL_SRC_LO];
                        next_r.ls_snk = wr_data[`GDCL_SNK_HI:`GDCL_SNK_LO];
                    end
                    if (!locked && wr_strb[`GDCL_STRB_HIGH]) begin
                        next_r.cbc    = wr_data[`GDCL_CBC_BIT];
                        next_r.peak_drive_time = wr_data[`GDCL_PEAK_DRIVE_TIME_HI:`GDCL_PEAK_DRIVE_TIME_LO];
                    end
                end
                default: begin
                end
            endcase
        end
        next_r.drive_cycles = drive_cycles(next_r.peak_drive_time);
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            r.lock         <= `GDCL_LOCK_OFF;
            r.hs_src       <= `GDCL_CURRENT_RST;
            r.hs_snk       <= `GDCL_CURRENT_RST;
            r.ls_src       <= `GDCL_CURRENT_RST;
            r.ls_snk       <= `GDCL_CURRENT_RST;
            r.peak_drive_time       <= `GDCL_PEAK_DRIVE_TIME_RST;
            r.drive_cycles <= 8'(`GDCL_TDRIVE3_NS / `GDCL_CLK_NS);
            r.cbc          <= `GDCL_CBC_RST;
            r.coast        <= 1'b0;
            r.brake        <= 1'b0;
            r.clr_pulse    <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // overcurrent fault clearing, one engine per fault source
    // ----------------------------------------------------------------
    assign oc_detect = {SENSE_OVERCURRENT, DRAIN_SOURCE_OVERCURRENT};

    for (genvar i = 0; i < 2; i++) begin : g_oc
        gdcl_retry #(
            .LONG_CYCLES (RETRY_LONG_CYCLES)
        ) u_retry (
            .clk       (MCLK),
            .rstn      (RSTN),
            .mode      (OVERCURRENT_MODE),
            .cbc       (r.cbc),
            .retry_sel (RETRY_TIME_SELECT),
            .clr_flt   (r.clr_pulse),
            .detect    (oc_detect[i]),
            .pwm_new   (PWM_NEW_INPUT),
            .fault     (oc_fault[i])
        );
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign DRAIN_SOURCE_OVERCURRENT_FAULT = oc_fault[0];
    assign SENSE_OVERCURRENT_FAULT        = oc_fault[1];
    assign HIGH_SIDE_SOURCE_CURRENT       = r.hs_src;
    assign HIGH_SIDE_SINK_CURRENT         = r.hs_snk;
    assign LOW_SIDE_SOURCE_CURRENT        = r.ls_src;
    assign LOW_SIDE_SINK_CURRENT          = r.ls_snk;
    assign PEAK_DRIVE_TIME                = r.peak_drive_time;
    assign PEAK_DRIVE_CYCLES              = r.drive_cycles;
    assign CYCLE_BY_CYCLE_CLEAR           = r.cbc;
    assign REGS_LOCKED                    = locked;
    assign COAST                          = r.coast;
    assign BRAKE                          = r.brake;
    assign CLEAR_FAULT                    = r.clr_pulse;

endmodule : gdcl_top
`default_nettype wire
